// ==== hw/pepp_pkg.sv ====
// constants and types shared by the parallel eeprom page-program host
package pepp_pkg;
  // clock period of the host logic
  localparam int CLK_PERIOD_NS = 10;
  // least write strobe low time, rounded up to whole cycles
  localparam int WP_NS = 200;
  localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least write strobe high time between two strobes
  localparam int WPH_NS = 100;
  localparam int WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // worst address/select to data delay on a read
  localparam int ACC_NS = 200;
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least output gate high pulse between two status reads
  localparam int OEHP_NS = 150;
  localparam int OEHP_CYC = (OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // byte_load_window, a longest time, so rounded down
  localparam int BLC_US = 150;
  localparam int BLC_CYC = BLC_US * 1000 / CLK_PERIOD_NS;
  // internal_program_period, the host waits at least this long before giving up
  localparam int PGM_MS = 10;
  localparam int PGM_CYC = (PGM_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // hold time of the high-voltage erase condition, same figure as a program period
  localparam int ERASE_CYC = PGM_CYC;
  // bytes in one page and width of the byte_in_page_bits field
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_LSB = 6;
  // write_unlock_protection command words (address, data); values are arbitrary
  localparam logic [14:0] UNLOCK_ADDR0 = 15'h1555;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h0AAA;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h1555;
  localparam logic [7:0] UNLOCK_DATA0 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'h55;
  localparam logic [7:0] UNLOCK_DATA2 = 8'hA0;
  // bit positions of the two status bits returned while programming
  localparam int POLLING_STATUS_BIT = 7;
  localparam int ALTERNATING_STATUS_BIT = 6;
  // user command codes
  typedef enum logic [1:0] {
    PEPP_OP_READ = 2'b00,
    PEPP_OP_WRITE = 2'b01,
    PEPP_OP_ERASE = 2'b10
  } pepp_op_type;
  // sequencer states
  typedef enum logic [2:0] {
    PEPP_IDLE = 3'b000,
    PEPP_WLOW = 3'b001,
    PEPP_WHIGH = 3'b010,
    PEPP_GAP = 3'b011,
    PEPP_PWAIT = 3'b100,
    PEPP_RLOW = 3'b101,
    PEPP_RHIGH = 3'b110,
    PEPP_ERASE = 3'b111
  } pepp_st_type;
endpackage : pepp_pkg

// ==== hw/pepp_host.sv ====
// host controller driving a byte-wide parallel eeprom through its pins
//
// Contract
// - write only: select low, gate high, strobe low
// - erase: select, strobe low, gate high-voltage
// - next byte within byte_load_window, else programs
// - one to sixty-four bytes per page
// - three unlock writes precede every write; the host sends them only before the first byte of each page load
// - page_select_bits constant across one page load
`timescale 1ns/100ps
module pepp_host #(
  parameter int BLC_CYCLES = pepp_pkg::BLC_CYC,
  parameter int PGM_CYCLES = pepp_pkg::PGM_CYC,
  parameter int ERASE_CYCLES = pepp_pkg::ERASE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // user command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [14:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_last,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic wr_done,
  output logic wr_timeout,
  output logic busy,
  // eeprom pins
  output logic ee_ce_b,
  output logic ee_oe_b,
  output logic ee_oe_hv,
  output logic ee_we_b,
  output logic [14:0] ee_addr,
  output logic [7:0] ee_data_o,
  output logic ee_data_oe_b,
  input wire logic [7:0] ee_data_i
);

  // whole state of the host in one word
  typedef struct packed {
    pepp_pkg::pepp_st_type st; // sequencer state
    logic [19:0] cnt; // phase timer inside one pin cycle
    logic [19:0] bw; // cycles since the last strobe fell
    logic [19:0] pgm; // cycles since the page load closed
    logic [1:0] unl; // unlock words sent, 3 means user bytes follow
    logic [6:0] nb; // user bytes loaded in this page
    logic [14:0] addr; // last user address written
    logic [7:0] wdat; // last user byte written
    logic [7:0] rdat; // byte just read
    logic [7:0] prev; // previous status read
    logic first; // no earlier status read yet
    logic last_seen; // user flagged the final byte
    logic poll; // current read is a status poll
    logic rd_valid;
    logic wr_done;
    logic wr_timeout;
    logic ce_b;
    logic oe_b;
    logic oe_hv;
    logic we_b;
    logic [14:0] pa; // address on the pins
    logic [7:0] pd; // data on the pins
    logic drv_b; // low while the host drives the data pins
  } pepp_state_type;

  pepp_state_type r;
  pepp_state_type next_r;
  logic accept_gap; // a further page byte is taken this cycle

  // unlock command address for step idx
  function automatic logic [14:0] unlock_addr(input logic [1:0] idx);
    unique case (idx)
      2'h0: unlock_addr = pepp_pkg::UNLOCK_ADDR0;
      2'h1: unlock_addr = pepp_pkg::UNLOCK_ADDR1;
      default: unlock_addr = pepp_pkg::UNLOCK_ADDR2;
    endcase
  endfunction : unlock_addr

  // unlock command data for step idx
  function automatic logic [7:0] unlock_data(input logic [1:0] idx);
    unique case (idx)
      2'h0: unlock_data = pepp_pkg::UNLOCK_DATA0;
      2'h1: unlock_data = pepp_pkg::UNLOCK_DATA1;
      default: unlock_data = pepp_pkg::UNLOCK_DATA2;
    endcase
  endfunction : unlock_data

  // a page byte is taken only while the window is surely open, on the same page, below 64 bytes
  assign accept_gap = (r.st == pepp_pkg::PEPP_GAP) && cmd_valid &&
                      (cmd_op == pepp_pkg::PEPP_OP_WRITE) && !r.last_seen &&
                      (cmd_addr[14:pepp_pkg::PAGE_LSB] == r.addr[14:pepp_pkg::PAGE_LSB]) &&
                      (r.nb < 7'(pepp_pkg::PAGE_BYTES)) &&
                      ((r.bw + 20'h2) < 20'(BLC_CYCLES));
  assign cmd_ready = (r.st == pepp_pkg::PEPP_IDLE) || accept_gap;

  // next-state logic
  always_comb
  begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.wr_done = 1'b0;
    next_r.wr_timeout = 1'b0;
    next_r.cnt = r.cnt + 20'h1;
    // byte window and program timers saturate rather than wrap
    if (r.bw != 20'hFFFFF)
    begin
      next_r.bw = r.bw + 20'h1;
    end
    if (r.pgm != 20'hFFFFF)
    begin
      next_r.pgm = r.pgm + 20'h1;
    end
    unique case (r.st)
      pepp_pkg::PEPP_IDLE:
      begin
        next_r.cnt = 20'h0;
        if (cmd_valid)
        begin
          if (cmd_op == pepp_pkg::PEPP_OP_READ)
          begin
            // plain read: select and gate low, strobe stays high
            next_r.pa = cmd_addr;
            next_r.ce_b = 1'b0;
            next_r.oe_b = 1'b0;
            next_r.poll = 1'b0;
            next_r.st = pepp_pkg::PEPP_RLOW;
          end
          else if (cmd_op == pepp_pkg::PEPP_OP_WRITE)
          begin
            // each write opens with the unlock words since protection re-armed
            next_r.addr = cmd_addr;
            next_r.wdat = cmd_wdata;
            next_r.last_seen = cmd_last;
            next_r.unl = 2'h0;
            next_r.nb = 7'h0;
            next_r.pa = unlock_addr(2'h0);
            next_r.pd = unlock_data(2'h0);
            next_r.ce_b = 1'b0;
            next_r.oe_b = 1'b1;
            next_r.we_b = 1'b0;
            next_r.drv_b = 1'b0;
            next_r.bw = 20'h0;
            next_r.st = pepp_pkg::PEPP_WLOW;
          end
          else if (cmd_op == pepp_pkg::PEPP_OP_ERASE)
          begin
            // erase: data pins left floating while the gate sits at high voltage
            next_r.ce_b = 1'b0;
            next_r.we_b = 1'b0;
            next_r.oe_b = 1'b1;
            next_r.oe_hv = 1'b1;
            next_r.drv_b = 1'b1;
            next_r.st = pepp_pkg::PEPP_ERASE;
          end
        end
      end
      pepp_pkg::PEPP_WLOW:
      begin
        // hold the strobe low for the least pulse width
        if (r.cnt == 20'(pepp_pkg::WP_CYC - 1))
        begin
          next_r.we_b = 1'b1;
          next_r.cnt = 20'h0;
          next_r.st = pepp_pkg::PEPP_WHIGH;
        end
      end
      pepp_pkg::PEPP_WHIGH:
      begin
        // strobe high time; data held through it, then next word or the gap
        if (r.cnt == 20'(pepp_pkg::WPH_CYC - 1))
        begin
          next_r.cnt = 20'h0;
          if (r.unl != 2'h3)
          begin
            next_r.unl = r.unl + 2'h1;
            next_r.pa = (r.unl == 2'h2) ? r.addr : unlock_addr(r.unl + 2'h1);
            next_r.pd = (r.unl == 2'h2) ? r.wdat : unlock_data(r.unl + 2'h1);
            next_r.we_b = 1'b0;
            next_r.bw = 20'h0;
            next_r.st = pepp_pkg::PEPP_WLOW;
          end
          else
          begin
            // user byte done: release the bus and wait for the next one
            next_r.nb = r.nb + 7'h1;
            next_r.ce_b = 1'b1;
            next_r.drv_b = 1'b1;
            next_r.st = pepp_pkg::PEPP_GAP;
          end
        end
      end
      pepp_pkg::PEPP_GAP:
      begin
        if (accept_gap)
        begin
          next_r.addr = cmd_addr;
          next_r.wdat = cmd_wdata;
          next_r.last_seen = cmd_last;
          next_r.pa = cmd_addr;
          next_r.pd = cmd_wdata;
          next_r.ce_b = 1'b0;
          next_r.we_b = 1'b0;
          next_r.drv_b = 1'b0;
          next_r.bw = 20'h0;
          next_r.cnt = 20'h0;
          next_r.st = pepp_pkg::PEPP_WLOW;
        end
        else if (r.last_seen || (r.nb == 7'(pepp_pkg::PAGE_BYTES)) || ((r.bw + 20'h2) >= 20'(BLC_CYCLES)) ||
                 (cmd_valid && !accept_gap))
        begin
          // close the page; an unfit command waits in idle until programming ends
          next_r.pgm = 20'h0;
          next_r.st = pepp_pkg::PEPP_PWAIT;
        end
      end
      pepp_pkg::PEPP_PWAIT:
      begin
        // let the window lapse so the device surely started programming
        if (r.bw >= 20'(BLC_CYCLES))
        begin
          next_r.pa = r.addr; // status is read at the last byte written
          next_r.ce_b = 1'b0;
          next_r.oe_b = 1'b0;
          next_r.poll = 1'b1;
          next_r.first = 1'b1;
          next_r.cnt = 20'h0;
          next_r.st = pepp_pkg::PEPP_RLOW;
        end
      end
      pepp_pkg::PEPP_RLOW:
      begin
        // sample after the worst access time, then raise gate and select
        if (r.cnt == 20'(pepp_pkg::ACC_CYC - 1))
        begin
          next_r.rdat = ee_data_i;
          next_r.ce_b = 1'b1;
          next_r.oe_b = 1'b1;
          next_r.cnt = 20'h0;
          next_r.st = pepp_pkg::PEPP_RHIGH;
        end
      end
      pepp_pkg::PEPP_RHIGH:
      begin
        // gate high pulse; also spaces successive status reads
        if (r.cnt == 20'(pepp_pkg::OEHP_CYC - 1))
        begin
          next_r.cnt = 20'h0;
          next_r.st = pepp_pkg::PEPP_IDLE;
          if (!r.poll)
          begin
            next_r.rd_valid = 1'b1;
          end
          else if (!r.first && (r.prev[pepp_pkg::ALTERNATING_STATUS_BIT] ==
                   r.rdat[pepp_pkg::ALTERNATING_STATUS_BIT]) &&
                   (r.rdat[pepp_pkg::POLLING_STATUS_BIT] == r.wdat[pepp_pkg::POLLING_STATUS_BIT]))
          begin
            // both status bits settled: programming over, device re-protected
            next_r.wr_done = 1'b1;
          end
          else if (r.pgm >= 20'(PGM_CYCLES))
          begin
            // no new write was tried meanwhile; the device owes an end by now
            next_r.wr_timeout = 1'b1;
          end
          else
          begin
            next_r.prev = r.rdat;
            next_r.first = 1'b0;
            next_r.ce_b = 1'b0;
            next_r.oe_b = 1'b0;
            next_r.st = pepp_pkg::PEPP_RLOW;
          end
        end
      end
      pepp_pkg::PEPP_ERASE:
      begin
        // hold the erase condition, then drop everything back to standby
        if (r.cnt == 20'(ERASE_CYCLES - 1))
        begin
          next_r.ce_b = 1'b1;
          next_r.we_b = 1'b1;
          next_r.oe_hv = 1'b0;
          next_r.wr_done = 1'b1;
          next_r.cnt = 20'h0;
          next_r.st = pepp_pkg::PEPP_IDLE;
        end
      end
    endcase
  end

  // state register; the clock enable freezes everything except the synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.st <= pepp_pkg::PEPP_IDLE;
      r.ce_b <= 1'b1; // standby after reset
      r.oe_b <= 1'b1;
      r.we_b <= 1'b1;
      r.drv_b <= 1'b1;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  // outputs straight from the state word
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rdat;
  assign wr_done = r.wr_done;
  assign wr_timeout = r.wr_timeout;
  assign busy = (r.st != pepp_pkg::PEPP_IDLE);
  assign ee_ce_b = r.ce_b;
  assign ee_oe_b = r.oe_b;
  assign ee_oe_hv = r.oe_hv;
  assign ee_we_b = r.we_b;
  assign ee_addr = r.pa;
  assign ee_data_o = r.pd;
  assign ee_data_oe_b = r.drv_b;

endmodule : pepp_host

// ==== verif/pepp_eeprom_model.sv ====
// behavioural model of the byte-wide eeprom seen at the host's pins
`timescale 1ns/100ps
module pepp_eeprom_model #(
  parameter int BLC = 40
) (
  input wire logic clk,
  input wire logic [31:0] prog_len, // program time in cycles, a 4-state net as ports need
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic oe_hv,
  input wire logic we_b,
  input wire logic [14:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [0:32767]; // array contents
  logic [22:0] key [3]; // unlock words as address and data
  logic [7:0] last_d; // last byte loaded
  logic [7:0] last_out; // last byte driven
  logic we_q, oe_q, load, tog, era; // pin history and modes
  int unl, prog, win, cnt; // unlock step, timer, window, bytes loaded in the page
  initial
  begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'h3C;
    key = '{{pepp_pkg::UNLOCK_ADDR0, pepp_pkg::UNLOCK_DATA0}, {pepp_pkg::UNLOCK_ADDR1, pepp_pkg::UNLOCK_DATA1},
      {pepp_pkg::UNLOCK_ADDR2, pepp_pkg::UNLOCK_DATA2}};
    {we_q, oe_q, load, tog, era, unl, prog, win, cnt, last_out, last_d} = '1;
    {load, era, unl, prog, cnt} = '0;
  end
  // strobes are judged on the rising edge, where the data is latched
  always @(posedge clk)
  begin
    we_q <= we_b;
    oe_q <= oe_b;
    if (!ce_b && !we_b && oe_hv) era <= 1'b1;
    if (!oe_hv && era)
    begin
      era <= 1'b0;
      for (int i = 0; i < 32768; i++) mem[i] <= 8'hFF;
    end
    if (prog > 0) prog <= prog - 1;
    else if (load && (win >= BLC || cnt == 64))
    begin
      load <= 1'b0;
      unl <= 0;
      prog <= int'(prog_len);
    end
    win <= (!we_b && we_q) ? 0 : win + 1;
    if (we_b && !we_q && !ce_b && oe_b && !oe_hv && prog == 0)
    begin
      if (unl < 3) unl <= (key[unl] == {addr, din}) ? unl + 1 : 0;
      else
      begin
        mem[addr] <= din;
        last_d <= din;
        load <= 1'b1;
        cnt <= load ? cnt + 1 : 1;
      end
    end
    if (oe_b && !oe_q && prog > 0) tog <= ~tog;
    if (!ce_b && !oe_b && we_b) last_out <= dout;
  end
  // a released bus shows the inverse of the last byte, never a held value
  always_comb
    if (!ce_b && !oe_b && we_b && !oe_hv)
      dout = (prog > 0) ? {~last_d[7], tog, last_d[5:0]} : mem[addr];
    else
      dout = ~last_out;
endmodule : pepp_eeprom_model

// ==== verif/pepp_host_chk.sv ====
// pin and command-port assertions for the eeprom host
`timescale 1ns/100ps
module pepp_host_chk #(
  parameter int BLC_CYCLES = 40,
  parameter int ERASE_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic rd_valid,
  input wire logic wr_done,
  input wire logic wr_timeout,
  input wire logic busy,
  input wire logic ee_ce_b,
  input wire logic ee_oe_b,
  input wire logic ee_oe_hv,
  input wire logic ee_we_b,
  input wire logic [14:0] ee_addr,
  input wire logic [7:0] ee_data_o,
  input wire logic ee_data_oe_b
);
  localparam int E_LO = ERASE_CYCLES;
  localparam int E_HI = ERASE_CYCLES + 2;
  logic take; // command taken at this edge
  int low_len; // cycles the strobe has been low
  int gap; // cycles since the previous strobe fall
  logic rd_seen; // a read or erase since that fall
  assign take = cmd_valid && cmd_ready && clk_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // counters feeding the timing checks
  always_ff @(posedge clk)
    if (!rst_b)
    begin
      low_len <= 0;
      gap <= 0;
      rd_seen <= 1'b1;
    end
    else
    begin
      low_len <= ee_we_b ? 0 : low_len + 1;
      gap <= $fell(ee_we_b) ? 1 : gap + 1;
      rd_seen <= $fell(ee_we_b) ? 1'b0 : (rd_seen || !ee_oe_b || ee_oe_hv);
    end
  a_gate_read_only: assert property (!ee_oe_b |-> !ee_ce_b && ee_we_b && ee_data_oe_b)
    else $error("output gate low outside a read");
  a_write_mode: assert property (!ee_data_oe_b |-> !ee_ce_b && ee_oe_b && !ee_oe_hv)
    else $error("data driven outside write mode");
  a_erase_mode: assert property (ee_oe_hv |-> !ee_ce_b && !ee_we_b && ee_data_oe_b)
    else $error("high voltage gate outside erase mode");
  a_strobe_width: assert property ($rose(ee_we_b) |-> low_len >= pepp_pkg::WP_CYC)
    else $error("write strobe too short");
  a_addr_held: assert property (!ee_we_b && $past(ee_we_b) == 1'b0 |-> $stable(ee_addr) && $stable(ee_data_o))
    else $error("address or data moved under the strobe");
  a_byte_window: assert property ($fell(ee_we_b) |-> rd_seen || gap < BLC_CYCLES)
    else $error("page byte after the load window");
  a_unlock_first: assert property ($fell(ee_we_b) && rd_seen && !ee_oe_hv |->
    ee_addr == pepp_pkg::UNLOCK_ADDR0 && ee_data_o == pepp_pkg::UNLOCK_DATA0)
    else $error("write not opened by unlock word");
  a_read_timing: assert property (take && cmd_op == 2'b00 |-> ##1 (!ee_ce_b && !ee_oe_b) ##35 rd_valid)
    else $error("read answer late or missing");
  a_erase_time: assert property (take && cmd_op == 2'b10 |-> ##[E_LO:E_HI] wr_done)
    else $error("erase completion out of range");
  a_idle_standby: assert property (!busy |-> ee_ce_b && ee_we_b && ee_data_oe_b)
    else $error("pins active while idle");
  c_read: cover property (take && cmd_op == 2'b00);
  c_erase: cover property (take && cmd_op == 2'b10);
  c_done: cover property (wr_done);
  c_timeout: cover property (wr_timeout);
endmodule : pepp_host_chk
bind pepp_host pepp_host_chk #(.BLC_CYCLES(BLC_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b),
  .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rd_valid(rd_valid),
  .wr_done(wr_done), .wr_timeout(wr_timeout), .busy(busy), .ee_ce_b(ee_ce_b), .ee_oe_b(ee_oe_b), .ee_oe_hv(ee_oe_hv),
  .ee_we_b(ee_we_b), .ee_addr(ee_addr), .ee_data_o(ee_data_o), .ee_data_oe_b(ee_data_oe_b));

// ==== verif/pepp_host_bench.sv ====
// self-checking bench for the eeprom page-program host
`timescale 1ns/100ps
module pepp_host_bench;
  localparam int BLC = 40; // shortened byte load window
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'b00;
  logic [14:0] cmd_addr = 15'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_last = 1'b0;
  logic clk_en = 1'b1; // dropped only by the freeze scenario
  logic cmd_ready, rd_valid, wr_done, wr_timeout, busy;
  logic ee_ce_b, ee_oe_b, ee_oe_hv, ee_we_b, ee_data_oe_b;
  logic [14:0] ee_addr;
  logic [7:0] rd_data, ee_data_o, ee_data_i, dev_out;
  int prog_len = 300; // device program time in cycles
  int fails = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  // the data wire: host when it drives, otherwise the device
  assign ee_data_i = ee_data_oe_b ? dev_out : ee_data_o;
  pepp_host #(.BLC_CYCLES(BLC), .PGM_CYCLES(2000), .ERASE_CYCLES(50)) DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_last(cmd_last), .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done), .wr_timeout(wr_timeout),
    .busy(busy), .ee_ce_b(ee_ce_b), .ee_oe_b(ee_oe_b), .ee_oe_hv(ee_oe_hv), .ee_we_b(ee_we_b), .ee_addr(ee_addr),
    .ee_data_o(ee_data_o), .ee_data_oe_b(ee_data_oe_b), .ee_data_i(ee_data_i));
  pepp_eeprom_model #(.BLC(BLC)) dev (.clk(clk), .prog_len(prog_len), .ce_b(ee_ce_b), .oe_b(ee_oe_b),
    .oe_hv(ee_oe_hv), .we_b(ee_we_b), .addr(ee_addr), .din(ee_data_i), .dout(dev_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // hold a command until the host takes it; valid stays up for the caller
  task automatic send(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d, input logic last);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_last <= last;
    cmd_valid <= 1'b1;
    #1;
    while (cmd_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk);
  endtask : send
  // bounded wait for a one-cycle answer: 0 read, 1 done, 2 timeout
  task automatic await(input int which, output logic seen);
    int n;
    n = 0;
    seen = 1'b0;
    while (!seen && n < 20000)
    begin
      @(posedge clk);
      n++;
      seen = ((which == 0) ? rd_valid : (which == 1) ? wr_done : wr_timeout) === 1'b1;
    end
  endtask : await
  task automatic read_chk(input logic [14:0] a, input logic [7:0] exp);
    logic ok;
    send(2'b00, a, 8'h00, 1'b0);
    cmd_valid <= 1'b0;
    await(0, ok);
    check(ok, 1'b1, "read answer");
    check(rd_data, exp, "read data");
  endtask : read_chk
  // load n bytes of one page, wait for programming, read them all back
  task automatic page(input logic [14:0] base, input int n, input logic use_last);
    logic ok;
    for (int i = 0; i < n; i++)
      send(2'b01, base + 15'(i), base[7:0] ^ 8'(i * 3), use_last && i == n - 1);
    cmd_valid <= 1'b0;
    await(1, ok);
    check(ok, 1'b1, "page done");
    for (int i = 0; i < n; i++)
      read_chk(base + 15'(i), base[7:0] ^ 8'(i * 3));
  endtask : page
  // a device slower than the host's limit must end in a timeout
  task automatic slow_chk();
    logic ok;
    prog_len = 3000;
    send(2'b01, 15'h0200, 8'hC3, 1'b1);
    cmd_valid <= 1'b0;
    await(2, ok);
    check(ok, 1'b1, "host timeout");
    repeat (1500) @(posedge clk);
    prog_len = 300;
    read_chk(15'h0200, 8'hC3);
  endtask : slow_chk
  // chip erase blanks a byte written earlier
  task automatic erase_chk();
    logic ok;
    send(2'b10, 15'h0000, 8'h00, 1'b0);
    cmd_valid <= 1'b0;
    await(1, ok);
    check(ok, 1'b1, "erase done");
    read_chk(15'h0080, 8'hFF);
  endtask : erase_chk
  // unused op code is dropped; a frozen host must not take a pending read
  task automatic freeze_chk();
    logic ok;
    send(2'b11, 15'h0000, 8'h00, 1'b0);
    cmd_valid <= 1'b0;
    @(posedge clk);
    check({busy, ee_ce_b}, 2'b01, "ignored op");
    clk_en <= 1'b0;
    cmd_op <= 2'b00;
    cmd_addr <= 15'h0123;
    cmd_valid <= 1'b1;
    repeat (8) @(posedge clk);
    check({busy, ee_ce_b}, 2'b01, "frozen host");
    clk_en <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    await(0, ok);
    check(ok, 1'b1, "read after freeze");
    check(rd_data, 8'h1F, "data after freeze");
  endtask : freeze_chk
  // commands unfit for the open page close it and wait for idle
  task automatic refuse_chk();
    logic ok;
    send(2'b01, 15'h0340, 8'h5A, 1'b0);
    send(2'b01, 15'h0380, 8'hA5, 1'b1);
    cmd_valid <= 1'b0;
    await(1, ok);
    check(ok, 1'b1, "second page done");
    read_chk(15'h0340, 8'h5A);
    read_chk(15'h0380, 8'hA5);
    send(2'b01, 15'h0300, 8'hC6, 1'b0);
    read_chk(15'h0300, 8'hC6);
  endtask : refuse_chk
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({ee_ce_b, ee_oe_b, ee_we_b, ee_data_oe_b, ee_oe_hv}, 8'h1E, "idle pins");
    read_chk(15'h0123, 8'h1F);
    freeze_chk();
    page(15'h0040, 1, 1'b1);
    page(15'h0080, 64, 1'b1);
    page(15'h0100, 3, 1'b0);
    refuse_chk();
    slow_chk();
    erase_chk();
    end_of_test();
  end
  // hang guard, well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule : pepp_host_bench
